// *** hdl/rng_defines.vh ***
/*
 Register offsets, field positions, reset values and timing counts of the random source.
 Assumes a 250 MHz system clock and an AHB-Lite slave port with 32-bit data.
*/
`ifndef RNG_DEFINES_VH
`define RNG_DEFINES_VH

`define RNG_CONFIG_OFFSET 8'h00
`define RNG_STATUS_OFFSET 8'h04
`define RNG_VALUE_OFFSET 8'h08
`define RNG_ADDR_BITS 8
`define RNG_GEN_OFF_POS 2
`define RNG_READY_POS 0
`define RNG_VALUE_BITS 16
`define RNG_RESET_WORD 32'h00000000
`define RNG_SIZE_WORD 3'b010
`define RNG_CLK_PERIOD_PS 4000
`define RNG_MIN_PERIOD_PS 1250000
`define RNG_MIN_PERIOD_NS_X1000 1250
`define RNG_PERIOD_CYCLES ((`RNG_MIN_PERIOD_NS_X1000 + `RNG_CLK_PERIOD_PS / 1000 - 1) / (`RNG_CLK_PERIOD_PS / 1000))
`define RNG_LFSR_SEED 32'h1d872b41

`endif

// *** hdl/noise_sampler.v ***
/*
 Stand-in for the analog noise source: two free-running ring-style LFSRs with
 different lengths mixed together, and a pacing counter that offers one fresh
 16-bit sample per minimum period.
 Assumes gen_off gates the whole source; while high nothing advances.
*/
`default_nettype none
`include "rng_defines.vh"

module noise_sampler (
    input wire sys_clk,
    input wire rst_b,
    input wire gen_off,
    output reg sample_valid,
    output reg [15:0] sample_data
);
    reg [31:0] lfsr_a_q;
    reg [16:0] lfsr_b_q;
    reg [15:0] pace_q;

    // Last count of the pacing counter before a sample is offered.
    localparam integer PACE_LAST = `RNG_PERIOD_CYCLES - 1;

    function [31:0] step_a;
        input [31:0] s;
        begin
            step_a = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
    endfunction

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lfsr_a_q <= `RNG_LFSR_SEED;
            lfsr_b_q <= 17'h1;
            pace_q <= 16'h0000;
            sample_valid <= 1'b0;
            sample_data <= 16'h0000;
        end
        else if (gen_off)
        begin
            // Oscillators powered down and the source clock stopped.
            sample_valid <= 1'b0;
        end
        else
        begin
            lfsr_a_q <= step_a(lfsr_a_q);
            lfsr_b_q <= {lfsr_b_q[15:0], lfsr_b_q[16] ^ lfsr_b_q[13]};
            sample_valid <= 1'b0;
            if (pace_q == PACE_LAST[15:0])
            begin
                pace_q <= 16'h0000;
                sample_valid <= 1'b1;
                sample_data <= lfsr_a_q[31:16] ^ lfsr_b_q[15:0];
            end
            else
            begin
                pace_q <= pace_q + 16'h0001;
            end
        end
    end
endmodule // noise_sampler
`default_nettype wire

// *** hdl/true_random_source_regs.v ***
/*
 Register block of the true random source, an AHB-Lite slave with three
 32-bit registers: configuration, status and value.
 Assumes the host drives AHB-Lite on sys_clk and that hsel covers this block.
*/
`default_nettype none
`include "rng_defines.vh"

// Functional notes
// - Value register returns 16-bit result in low bits.
// - Only 32-bit accesses; narrower ones get error.
// - Fresh values at most one per 1.25 us.
// - Config bit 2 disables and gates generator.
// - Status bit 0 shows a ready value.
// - Early value read waits until value arrives.
// - Ready stays low while generator off.
// - Value read while generator off waits without end.
// - Registers at 0x00, 0x04, 0x08, reset zero.
module true_random_source_regs (
    input wire sys_clk,
    input wire rst_b,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp
);
    localparam ST_IDLE = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_ERR1 = 2'd2;
    localparam ST_ERR2 = 2'd3;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg gen_off_q;
    reg ready_q;
    reg [15:0] value_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    wire sample_valid;
    wire [15:0] sample_data;
    wire take;
    wire bad_size;
    wire [7:0] a;
    wire value_read;
    wire fresh;
    wire fast_read;
    wire slow_read;
    wire wait_hit;
    wire config_write;

    // True when a byte address selects the register at the given offset.
    function word_hit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            word_hit = addr == offset;
        end
    endfunction

    // Places a 16-bit random result in the low half of a bus word.
    function [31:0] value_word;
        input [15:0] v;
        begin
            value_word = {16'h0000, v};
        end
    endfunction

    assign take = hsel && hready && htrans[1];
    assign bad_size = hsize != `RNG_SIZE_WORD;
    assign a = haddr[7:0];
    assign value_read = take && !bad_size && !hwrite && word_hit(a, `RNG_VALUE_OFFSET);
    // A sample is only trusted while the generator runs.
    assign fresh = sample_valid && !gen_off_q;
    // With a value waiting, a value read finishes with no wait state.
    assign fast_read = value_read && ready_q && !gen_off_q;
    assign slow_read = value_read && !fast_read;
    // A waiting value read is finished by the first fresh sample.
    assign wait_hit = state_q == ST_WAIT && fresh;
    assign config_write = wr_pend_q && word_hit(wr_addr_q, `RNG_CONFIG_OFFSET);

    // The sampler paces fresh values to one per minimum period.
    noise_sampler u_noise (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .gen_off(gen_off_q),
        .sample_valid(sample_valid),
        .sample_data(sample_data)
    );

    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE, ST_ERR2:
            begin
                state_d = ST_IDLE;
                if (take && bad_size)
                begin
                    state_d = ST_ERR1;
                end
                else if (slow_read)
                begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                if (wait_hit)
                begin
                    state_d = ST_IDLE;
                end
            end
            ST_ERR1:
            begin
                state_d = ST_ERR2;
            end
            default:
            begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // The read data is loaded on the edge that leaves the wait, so ready rises with it.
    assign hreadyout = !(state_q == ST_ERR1 || state_q == ST_WAIT);
    assign hresp = state_q == ST_ERR1 || state_q == ST_ERR2;

    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Write data follows its address by one cycle, so the address is kept.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end
        else
        begin
            wr_pend_q <= take && hwrite && !bad_size;
            if (take)
            begin
                wr_addr_q <= a;
            end
        end
    end

    // Only the generator-off bit of the configuration register is stored.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            gen_off_q <= 1'b0;
        end
        else if (config_write)
        begin
            gen_off_q <= hwdata[`RNG_GEN_OFF_POS];
        end
    end

    // A sample that arrives with a consuming read goes to that read, so the flag ends low.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ready_q <= 1'b0;
            value_q <= 16'h0000;
        end
        else
        begin
            if (gen_off_q)
            begin
                ready_q <= 1'b0;
            end
            else if (fast_read || wait_hit)
            begin
                ready_q <= 1'b0;
            end
            else if (fresh)
            begin
                ready_q <= 1'b1;
            end
            if (fresh)
            begin
                value_q <= sample_data;
            end
        end
    end

    // Read data is registered and stands from the cycle in which hreadyout is high.
    always @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hrdata <= `RNG_RESET_WORD;
        end
        else if (take && !hwrite && !bad_size)
        begin
            if (word_hit(a, `RNG_CONFIG_OFFSET))
            begin
                hrdata <= {29'h0, gen_off_q, 2'b00};
            end
            else if (word_hit(a, `RNG_STATUS_OFFSET))
            begin
                hrdata <= {31'h0, ready_q};
            end
            else if (fast_read)
            begin
                hrdata <= value_word(fresh ? sample_data : value_q);
            end
            else if (!value_read)
            begin
                hrdata <= `RNG_RESET_WORD;
            end
        end
        else if (wait_hit)
        begin
            hrdata <= value_word(sample_data);
        end
    end
endmodule // true_random_source_regs
`default_nettype wire

// *** tb/trs_chk.sv ***
/* Assertions on the random source bus port.
   Assumes hready is the slave's own hreadyout looped back. */
`default_nettype none
module trs_chk (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    wire logic tk = hsel && hready && htrans[1];
    wire logic rd = tk && !hwrite && hsize == 3'b010;
    wire logic [7:0] a = haddr[7:0];
    size_err_a: assert property (tk && hsize != 3'b010 |=>
        hresp && !hreadyout ##1 hresp && hreadyout) else $error("no error");
    resp_cause_a: assert property ($rose(hresp) |-> $past(tk && hsize != 3'b010))
        else $error("stray error");
    fast_reg_a: assert property (rd && a != 8'h08 |=> hreadyout && !hresp)
        else $error("wait");
    status_bits_a: assert property (rd && a == 8'h04 |=> hrdata[31:1] == 31'h0)
        else $error("status");
    unmapped_zero_a: assert property (rd && a == 8'h0c |=> hrdata == 32'h0)
        else $error("unmapped");
    value_word_a: assert property (rd && a == 8'h08 |=> ##[0:320]
        (hreadyout && hrdata[31:16] == 16'h0)) else $error("value");
    wait_bound_a: assert property ($fell(hreadyout) && !hresp |-> ##[1:320] hreadyout)
        else $error("long wait");
    reset_out_a: assert property ($rose(rst_b) |-> hreadyout && !hresp && hrdata == 0)
        else $error("reset");
endmodule // trs_chk
`default_nettype wire

// *** tb/ahb_host.sv ***
/* Bus host model issuing single transfers.
   Assumes the slave's hreadyout also feeds its hready. */
`default_nettype none
module ahb_host (
    input wire logic sys_clk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = 0;
    task xfer(input logic [7:0] a, input logic [2:0] s, input logic w,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        @(posedge sys_clk);
        #1;
        {hsel, htrans, hwrite} = {1'b1, 2'b10, w};
        haddr = {24'h0, a};
        hsize = s;
        @(posedge sys_clk);
        #1;
        {hsel, htrans} = 0;
        haddr = ~haddr;
        hwdata = d;
        do @(negedge sys_clk); while (hreadyout !== 1'b1);
        {r, e} = {hrdata, hresp};
        @(posedge sys_clk);
    endtask
endmodule // ahb_host
`default_nettype wire

// *** tb/true_random_source_regs_bench.sv ***
/* Self-checking bench of the random source registers.
   Assumes the host model and the checker are compiled first. */
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin n_fail++; $display("ERROR %0t bad", $time); end end
module true_random_source_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0;
    logic rst_b = 0;
    logic hsel, hwrite, hreadyout, hresp, e;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, r;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    realtime t0;
    always #2 sys_clk = ~sys_clk;
    ahb_host host (.sys_clk(sys_clk), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata));
    true_random_source_regs uut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    task go(input logic [7:0] a, input logic [2:0] s, input logic w, input logic [31:0] d);
        host.xfer(a, s, w, d, r, e);
    endtask
    task stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            stop_test();
        end
    end
    initial
    begin
        repeat (6) @(posedge sys_clk);
        #1 rst_b = 1;
        go(8'h00, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        go(8'h0c, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        $display("reset test done");
        go(8'h08, 3'b010, 0, 0);
        t0 = $realtime;
        go(8'h08, 3'b010, 0, 0);
        `CHK({e, r[31:16]}, 17'h0)
        `CHK($realtime - t0 >= 1248.0, 1'b1)
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        repeat (330) @(posedge sys_clk);
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h1)
        go(8'h08, 3'b010, 0, 0);
        `CHK({e, r[31:16]}, 17'h0)
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        repeat (300) @(posedge sys_clk);
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h1)
        $display("value test done");
        go(8'h00, 3'b010, 1, 32'h4);
        go(8'h00, 3'b010, 0, 0);
        `CHK(r, 32'h4)
        repeat (400) @(posedge sys_clk);
        go(8'h04, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        go(8'h00, 3'b000, 1, 32'h0);
        `CHK(e, 1'b1)
        go(8'h00, 3'b010, 0, 0);
        `CHK(r, 32'h4)
        go(8'h00, 3'b010, 1, 32'h0);
        go(8'h00, 3'b010, 0, 0);
        `CHK(r, 32'h0)
        go(8'h08, 3'b010, 0, 0);
        `CHK({e, r[31:16]}, 17'h0)
        $display("config test done");
        stop_test();
    end
endmodule // true_random_source_regs_bench
bind true_random_source_regs trs_chk chk (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
